// >>> logic/pasl_bank.sv
/*
  per-port auxiliary control/status and led control register bank,
  reached over apb.
  assumes: status inputs synchronous to pclk; strap inputs stable
  around reset release; apb master per amba apb protocol.
*/
`timescale 1ns/1ps
`include "pasl_defines.svh"

module pasl_bank
  import pasl_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              aneg_complete,
  input  wire logic              aneg_enable,
  input  wire logic              crossover_done,
  input  wire logic              cd_pair_swap,
  input  wire logic [3:0]        pair_pol_inv,
  input  wire logic              full_duplex_flag,
  input  wire logic [1:0]        speed_code,
  input  wire logic [1:0]        media_code,
  input  wire logic [15:0]       config_strap_default,
  input  wire logic              config_strap_tmo_msb,
  output logic                   link_power_saver_en,
  output logic [1:0]             link_power_saver_tmo,
  output logic [15:0]            led_mode_sel,
  output logic                   led_extended_mode,
  output logic                   speed_link_indication_cu_only,
  output logic                   port_soft_reset
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic        lps_en_q, lps_en_d;
  logic [1:0]  tmo_q, tmo_d;
  logic [15:0] ledsel_q, ledsel_d;
  logic        cu_only_q, cu_only_d;
  logic [15:0] page_q, page_d;
  logic        extled_q, extled_d;
  logic        srst_q, srst_d;
  logic        strap_pend_q, strap_pend_d;
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  pasl_state_t st_q, st_d;

  // ****************************************************************
  // decode and read mux
  // ****************************************************************
  logic        main_page;
  logic        hit_bank;
  logic        hit_page;
  logic        hit_ctrl;
  logic        wr_lo;
  logic [15:0] aux_word;
  logic [15:0] rd_word;

  assign main_page = (page_q == `PASL_PAGE_MAIN);
  assign hit_page  = (paddr == ADDR_W'(`PASL_ADDR_PAGE));
  assign hit_ctrl  = (paddr == ADDR_W'(`PASL_ADDR_CTRL));
  assign hit_bank  = main_page &&
                     ((paddr == ADDR_W'(`PASL_ADDR_AUX)) ||
                      (paddr == ADDR_W'(`PASL_ADDR_LEDSEL)) ||
                      (paddr == ADDR_W'(`PASL_ADDR_LEDBEH)));
  // 16-bit registers: both low lanes must be strobed to write
  assign wr_lo     = pstrb[0] & pstrb[1];

  always_comb begin
    aux_word = 16'h0000;
    aux_word[`PASL_AUX_ANEG_DONE] = aneg_complete;
    aux_word[`PASL_AUX_ANEG_OFF]  = ~aneg_enable;
    aux_word[`PASL_AUX_XOVER]     = crossover_done;
    aux_word[`PASL_AUX_CDSWAP]    = cd_pair_swap;
    aux_word[`PASL_AUX_POL_HI:`PASL_AUX_POL_LO] = pair_pol_inv;
    aux_word[`PASL_AUX_TMO_MSB]   = tmo_q[1];
    aux_word[`PASL_AUX_LPS_EN]    = lps_en_q;
    aux_word[`PASL_AUX_FDX]       = full_duplex_flag;
    aux_word[`PASL_AUX_SPD_HI:`PASL_AUX_SPD_LO] = speed_code;
    aux_word[`PASL_AUX_TMO_LSB]   = tmo_q[0];
    aux_word[`PASL_AUX_MEDIA_HI:`PASL_AUX_MEDIA_LO] = media_code;
  end

  always_comb begin
    rd_word = 16'h0000;
    case (paddr)
      ADDR_W'(`PASL_ADDR_AUX):    rd_word = aux_word;
      ADDR_W'(`PASL_ADDR_LEDSEL): rd_word = ledsel_q;
      ADDR_W'(`PASL_ADDR_LEDBEH): rd_word = {cu_only_q, 15'h0000};
      ADDR_W'(`PASL_ADDR_PAGE):   rd_word = page_q;
      ADDR_W'(`PASL_ADDR_CTRL):   rd_word = {14'h0000, extled_q, srst_q};
      default:                    rd_word = 16'h0000;
    endcase
  end

  // ****************************************************************
  // apb slave and register next values
  // ****************************************************************
  logic access;
  logic hit_any;

  assign access  = psel & penable & (st_q == PASL_ST_ACCESS);
  assign hit_any = hit_bank | hit_page | hit_ctrl;

  always_comb begin
    st_d         = st_q;
    lps_en_d     = lps_en_q;
    tmo_d        = tmo_q;
    ledsel_d     = ledsel_q;
    cu_only_d    = cu_only_q;
    page_d       = page_q;
    extled_d     = extled_q;
    srst_d       = 1'b0;
    strap_pend_d = 1'b0;
    rdata_d      = rdata_q;
    err_d        = err_q;
    // strap defaults caught on the first edge after reset release
    if (strap_pend_q) begin
      ledsel_d = config_strap_default;
      tmo_d[1] = config_strap_tmo_msb;
    end
    case (st_q)
      PASL_ST_IDLE: begin
        if (psel && !penable) begin
          st_d    = PASL_ST_ACCESS;
          // off-page or unmapped reads return zero, not the hidden word
          rdata_d = {16'h0000, (hit_any ? rd_word : 16'h0000)};
          err_d   = ~hit_any;
        end
      end
      PASL_ST_ACCESS: begin
        st_d = PASL_ST_IDLE;
        if (access && pwrite && hit_any && wr_lo) begin
          case (paddr)
            ADDR_W'(`PASL_ADDR_AUX): begin
              // status bits come from inputs, so writes cannot touch them
              lps_en_d = pwdata[`PASL_AUX_LPS_EN];
              tmo_d    = {pwdata[`PASL_AUX_TMO_MSB], pwdata[`PASL_AUX_TMO_LSB]};
            end
            ADDR_W'(`PASL_ADDR_LEDSEL): ledsel_d = pwdata[15:0];
            ADDR_W'(`PASL_ADDR_LEDBEH): cu_only_d = pwdata[`PASL_BEH_CU_ONLY];
            ADDR_W'(`PASL_ADDR_PAGE):   page_d = pwdata[15:0];
            ADDR_W'(`PASL_ADDR_CTRL): begin
              extled_d = pwdata[`PASL_CTRL_EXTLED];
              srst_d   = pwdata[`PASL_CTRL_SRST];
            end
            default: begin
            end
          endcase
        end
      end
      default: st_d = PASL_ST_IDLE;
    endcase
    // soft reset leaves sticky bits alone; only the page returns to main
    if (srst_q) begin
      page_d = `PASL_PAGE_MAIN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q         <= PASL_ST_IDLE;
      lps_en_q     <= `PASL_RST_LPS_EN;
      tmo_q        <= {1'b0, `PASL_RST_TMO_LSB};
      ledsel_q     <= 16'h0000;
      cu_only_q    <= `PASL_RST_CU_ONLY;
      page_q       <= `PASL_PAGE_MAIN;
      extled_q     <= 1'b0;
      srst_q       <= 1'b0;
      strap_pend_q <= 1'b1;
      rdata_q      <= 32'h0000_0000;
      err_q        <= 1'b0;
    end else begin
      st_q         <= st_d;
      lps_en_q     <= lps_en_d;
      tmo_q        <= tmo_d;
      ledsel_q     <= ledsel_d;
      cu_only_q    <= cu_only_d;
      page_q       <= page_d;
      extled_q     <= extled_d;
      srst_q       <= srst_d;
      strap_pend_q <= strap_pend_d;
      rdata_q      <= rdata_d;
      err_q        <= err_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign pready                        = (st_q == PASL_ST_ACCESS);
  assign prdata                        = rdata_q;
  assign pslverr                       = pready & err_q;
  assign link_power_saver_en           = lps_en_q;
  assign link_power_saver_tmo          = tmo_q;
  assign led_mode_sel                  = ledsel_q;
  assign led_extended_mode             = extled_q;
  assign speed_link_indication_cu_only = cu_only_q;
  assign port_soft_reset               = srst_q;

endmodule : pasl_bank

// >>> shared/pasl_defines.svh
/*
  register offsets, field positions and reset values of the per-port
  auxiliary status / led control bank.
  assumes: included by the bank module, the checker and the bench by bare name.
*/
`ifndef PASL_DEFINES_SVH
`define PASL_DEFINES_SVH

// ****************************************************************
// offsets (byte addresses = index * 4)
// ****************************************************************
`define PASL_IDX_AUX      5'h1c
`define PASL_IDX_LEDSEL   5'h1d
`define PASL_IDX_LEDBEH   5'h1e
`define PASL_IDX_PAGE     5'h1f
`define PASL_ADDR_AUX     12'h070
`define PASL_ADDR_LEDSEL  12'h074
`define PASL_ADDR_LEDBEH  12'h078
`define PASL_ADDR_PAGE    12'h07c
`define PASL_ADDR_CTRL    12'h080

// ****************************************************************
// auxiliary word and led behaviour word field positions
// ****************************************************************
`define PASL_AUX_ANEG_DONE  15
`define PASL_AUX_ANEG_OFF   14
`define PASL_AUX_XOVER      13
`define PASL_AUX_CDSWAP     12
`define PASL_AUX_POL_HI     11
`define PASL_AUX_POL_LO     8
`define PASL_AUX_TMO_MSB    7
`define PASL_AUX_LPS_EN     6
`define PASL_AUX_FDX        5
`define PASL_AUX_SPD_HI     4
`define PASL_AUX_SPD_LO     3
`define PASL_AUX_TMO_LSB    2
`define PASL_AUX_MEDIA_HI   1
`define PASL_AUX_MEDIA_LO   0
`define PASL_BEH_CU_ONLY    15

// ****************************************************************
// control word (soft reset / extended led) positions
// ****************************************************************
`define PASL_CTRL_SRST      0
`define PASL_CTRL_EXTLED    1

// ****************************************************************
// reset values and timeouts
// ****************************************************************
`define PASL_RST_LPS_EN     1'b0
`define PASL_RST_TMO_LSB    1'b0
`define PASL_RST_CU_ONLY    1'b0
`define PASL_PAGE_MAIN      16'h0000
`define PASL_TMO_00_MS      2300
`define PASL_TMO_01_MS      3300
`define PASL_TMO_10_MS      4300
`define PASL_TMO_11_MS      5300

`endif

// >>> shared/pasl_pkg.sv
/*
  types of the auxiliary status / led control bank.
  assumes: nothing beyond the defines header.
*/
package pasl_pkg;

  // ****************************************************************
  // codes
  // ****************************************************************
  typedef enum logic [1:0] {
    PASL_SPD_10   = 2'h0,
    PASL_SPD_100  = 2'h1,
    PASL_SPD_1000 = 2'h2,
    PASL_SPD_RSVD = 2'h3
  } pasl_speed_t;

  typedef enum logic [1:0] {
    PASL_MEDIA_NONE   = 2'h0,
    PASL_MEDIA_COPPER = 2'h1,
    PASL_MEDIA_SERDES = 2'h2,
    PASL_MEDIA_RSVD   = 2'h3
  } pasl_media_t;

  typedef enum logic [1:0] {
    PASL_ST_IDLE   = 2'b00,
    PASL_ST_ACCESS = 2'b01
  } pasl_state_t;

endpackage : pasl_pkg

// >>> testbench/pasl_bank_props.sv
/* assertions on the apb side of the aux/led bank.
   assumes: bound to pasl_bank; one clock, async low reset. */
`timescale 1ns/1ps
`include "pasl_defines.svh"
module pasl_bank_props #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              aneg_complete,
  input wire logic              aneg_enable,
  input wire logic              crossover_done,
  input wire logic              cd_pair_swap,
  input wire logic [3:0]        pair_pol_inv,
  input wire logic              full_duplex_flag,
  input wire logic [1:0]        speed_code,
  input wire logic [1:0]        media_code,
  input wire logic              link_power_saver_en,
  input wire logic [1:0]        link_power_saver_tmo,
  input wire logic [15:0]       led_mode_sel,
  input wire logic              speed_link_indication_cu_only,
  input wire logic              port_soft_reset
);
  logic rd_a, rd_s, rd_b, wr_a;
  assign rd_a = psel && !penable && !pwrite && paddr == `PASL_ADDR_AUX;
  assign rd_s = psel && !penable && !pwrite && paddr == `PASL_ADDR_LEDSEL;
  assign rd_b = psel && !penable && !pwrite && paddr == `PASL_ADDR_LEDBEH;
  assign wr_a = psel && !penable && pwrite && &pstrb[1:0] && paddr == `PASL_ADDR_AUX;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************
  // read and write paths
  // ****************
  property p_an; rd_a |=> pslverr || prdata[15:14] == {$past(aneg_complete), !$past(aneg_enable)}; endproperty
  a_an: assert property (p_an) else $error("aneg mirror wrong");
  property p_pr; rd_a |=> pslverr || prdata[13:8] == $past({crossover_done, cd_pair_swap, pair_pol_inv}); endproperty
  a_pr: assert property (p_pr) else $error("pair status wrong");
  property p_ln; rd_a |=> pslverr || {prdata[5:3], prdata[1:0]} == $past({full_duplex_flag, speed_code, media_code});
  endproperty
  a_ln: assert property (p_ln) else $error("link status wrong");
  property p_lr; rd_a |=> pslverr || {prdata[7:6], prdata[2]} == $past({link_power_saver_tmo[1], link_power_saver_en,
    link_power_saver_tmo[0]}); endproperty
  a_lr: assert property (p_lr) else $error("saver bits read wrong");
  property p_sl; rd_s |=> pslverr || prdata[15:0] == $past(led_mode_sel); endproperty
  a_sl: assert property (p_sl) else $error("led select read wrong");
  property p_bh; rd_b |=> pslverr || prdata[15] == $past(speed_link_indication_cu_only); endproperty
  a_bh: assert property (p_bh) else $error("combine bit read wrong");
  property p_wr; wr_a ##1 !pslverr |=> link_power_saver_en == $past(pwdata[6]) &&
    link_power_saver_tmo == {$past(pwdata[7]), $past(pwdata[2])}; endproperty
  a_wr: assert property (p_wr) else $error("saver write lost");
  // a write committing on the same edge may change them legally
  property p_sr; port_soft_reset && !(psel && penable && pwrite) |=> $stable(led_mode_sel) &&
    $stable(link_power_saver_en); endproperty
  a_sr: assert property (p_sr) else $error("soft reset hit sticky bits");
  property p_er; pslverr |-> prdata == 32'h0000_0000; endproperty
  a_er: assert property (p_er) else $error("refused access returned data");
endmodule : pasl_bank_props

// >>> testbench/pasl_bank_tb_top.sv
/* self-checking apb bench of the aux/led bank.
   assumes: package, bank and checker compiled first. */
`timescale 1ns/1ps
`include "pasl_defines.svh"
module pasl_bank_tb_top
  import pasl_pkg::*;
;
  localparam logic [15:0] STRAP = 16'hc3a5;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, lps_en, ext_led, cu_only;
  logic        srst, strap_msb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic [12:0] st;
  logic [1:0]  lps_tmo;
  logic [15:0] led_sel;
  int          errors, total_checks;
  logic [12:0] pats [3] = '{13'h1555, 13'h0aaa, 13'h1c63};
  pasl_bank #(.ADDR_W(12)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .aneg_complete(st[12]), .aneg_enable(st[11]), .crossover_done(st[10]), .cd_pair_swap(st[9]),
    .pair_pol_inv(st[8:5]), .full_duplex_flag(st[4]), .speed_code(st[3:2]), .media_code(st[1:0]),
    .config_strap_default(STRAP), .config_strap_tmo_msb(strap_msb), .link_power_saver_en(lps_en),
    .link_power_saver_tmo(lps_tmo), .led_mode_sel(led_sel), .led_extended_mode(ext_led),
    .speed_link_indication_cu_only(cu_only), .port_soft_reset(srst));
  always #10 pclk = ~pclk;
  function automatic logic [31:0] aux(input logic [12:0] s, input logic l, input logic [1:0] t);
    return {16'h0, s[12], ~s[11], s[10:5], t[1], l, s[4:2], t[0], s[1:0]};
  endfunction : aux
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      errors++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed; pready is judged at rising edges only
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    xfer(1'b0, a, 16'h0);
    chk("prdata", x, r);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask : rchk
  task summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  // ****************
  // sequence
  // ****************
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, st} = '0;
    pstrb = 4'hf;
    strap_msb = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (pats[i]) begin
      st <= pats[i];
      rchk(`PASL_ADDR_AUX, aux(pats[i], 1'b0, 2'b10), 1'b0);
    end
    rchk(`PASL_ADDR_LEDSEL, {16'h0, STRAP}, 1'b0);
    rchk(`PASL_ADDR_LEDBEH, 32'h0, 1'b0);
    xfer(1'b1, `PASL_ADDR_AUX, 16'hffff);
    rchk(`PASL_ADDR_AUX, aux(pats[2], 1'b1, 2'b11), 1'b0);
    chk("saver", 32'h7, {29'h0, lps_en, lps_tmo});
    xfer(1'b1, `PASL_ADDR_AUX, 16'h0004);
    rchk(`PASL_ADDR_AUX, aux(pats[2], 1'b0, 2'b01), 1'b0);
    xfer(1'b1, `PASL_ADDR_LEDSEL, 16'h5a3c);
    rchk(`PASL_ADDR_LEDSEL, 32'h5a3c, 1'b0);
    chk("led_sel", 32'h5a3c, {16'h0, led_sel});
    xfer(1'b1, `PASL_ADDR_LEDBEH, 16'h8000);
    rchk(`PASL_ADDR_LEDBEH, 32'h8000, 1'b0);
    chk("cu_only", 32'h1, {31'h0, cu_only});
    xfer(1'b1, `PASL_ADDR_CTRL, 16'h0002);
    xfer(1'b1, `PASL_ADDR_PAGE, 16'h0001);
    chk("ext_led", 32'h1, {31'h0, ext_led});
    rchk(`PASL_ADDR_AUX, 32'h0, 1'b1);
    rchk(`PASL_ADDR_LEDSEL, 32'h0, 1'b1);
    rchk(12'h0a0, 32'h0, 1'b1);
    xfer(1'b1, `PASL_ADDR_CTRL, 16'h0003);
    @(negedge pclk);
    chk("soft_reset", 32'h1, {31'h0, srst});
    @(negedge pclk);
    chk("soft_reset", 32'h0, {31'h0, srst});
    rchk(`PASL_ADDR_LEDSEL, 32'h5a3c, 1'b0);
    rchk(`PASL_ADDR_AUX, aux(pats[2], 1'b0, 2'b01), 1'b0);
    xfer(1'b1, `PASL_ADDR_PAGE, 16'h0001);
    xfer(1'b1, `PASL_ADDR_LEDBEH, 16'h0000);
    chk("wr_err", 32'h1, {31'h0, e});
    rchk(`PASL_ADDR_PAGE, 32'h1, 1'b0);
    xfer(1'b1, `PASL_ADDR_PAGE, `PASL_PAGE_MAIN);
    rchk(`PASL_ADDR_LEDBEH, 32'h8000, 1'b0);
    strap_msb <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(`PASL_ADDR_LEDSEL, {16'h0, STRAP}, 1'b0);
    rchk(`PASL_ADDR_AUX, aux(pats[2], 1'b0, 2'b00), 1'b0);
    summarize();
  end
  // about 30 transfers of 3 cycles each; wide margin
  initial begin
    repeat (3000) @(posedge pclk);
    errors++;
    summarize();
  end
endmodule : pasl_bank_tb_top
bind pasl_bank pasl_bank_props #(.ADDR_W(ADDR_W)) u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pslverr, .aneg_complete, .aneg_enable, .crossover_done, .cd_pair_swap, .pair_pol_inv,
  .full_duplex_flag, .speed_code, .media_code, .link_power_saver_en, .link_power_saver_tmo, .led_mode_sel,
  .speed_link_indication_cu_only, .port_soft_reset);
